// ==== logic/heps_core.sv ====
// host endian swapping, power save and refresh path
//
// The address map and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/1ps
module heps_core (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic endian_select_strap_i,
  input wire logic pin_function_strap_i,
  input wire logic [heps_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [heps_pkg::DATA_W-1:0] avs_writedata_i,
  input wire logic [1:0] avs_byteenable_i,
  output logic [heps_pkg::DATA_W-1:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic [heps_pkg::DATA_W-1:0] panel_data_o,
  output logic panel_de_o,
  output logic panel_shift_o,
  output logic pwm_source_clock_o,
  input wire logic [heps_pkg::GPIO_W-1:0] gpio_i,
  output logic [heps_pkg::GPIO_W-1:0] gpio_o,
  output logic [heps_pkg::GPIO_W-1:0] gpio_oe_o,
  output logic power_save_o,
  output logic mc_down_o
);
  import heps_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    // bus sequencing and strap settling
    heps_state_t state;
    logic [1:0] settle_cnt;
    logic be_s1;
    logic be_s2;
    logic pf_s1;
    logic pf_s2;
    // straps as latched once after reset
    logic big_endian;
    logic pin_func;
    // software control fields
    logic ps_en;
    logic disp_swap;
    logic [GPIO_W-1:0] gpio_out;
    logic [GPIO_W-1:0] gpio_dir;
    // gpio synchroniser and pin drive
    logic [GPIO_W-1:0] gpio_s1;
    logic [GPIO_W-1:0] gpio_s2;
    logic [GPIO_W-1:0] gpio_pin;
    logic [GPIO_W-1:0] gpio_en;
    // read data held for the answer cycle
    logic [DATA_W-1:0] rdata;
    // refresh path and pwm source
    logic [BUF_AW-1:0] fetch_addr;
    logic [DATA_W-1:0] panel_data;
    logic panel_de;
    logic panel_shift;
    logic [PWM_W-1:0] pwm_cnt;
  } heps_core_t;

  heps_core_t s;
  heps_core_t next_s;

  // display buffer, no reset; words are undefined until written
  logic [DATA_W-1:0] buf_mem [BUF_DEPTH];
  // datapath between bus, buffer and panel
  logic [DATA_W-1:0] wd_le;
  logic [DATA_W-1:0] raw_rd;
  logic [DATA_W-1:0] rd_bus;
  logic [DATA_W-1:0] disp_word;
  logic [1:0] be_le;
  logic is_buf;
  logic buf_we;
  logic mc_down;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // register select by word address
  // bit 11 set selects the buffer, so registers decode only below it
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] r);
    hit = !a[BUF_SEL_BIT] && (a == r);
  endfunction

  // byte-lane merge of a write into an old word
  function automatic logic [DATA_W-1:0] merge(
    input logic [DATA_W-1:0] old,
    input logic [DATA_W-1:0] wd,
    input logic [1:0] be);
    logic [DATA_W-1:0] r;
    // lanes that are not enabled keep their old bits
    r = old;
    if (be[0]) begin
      r[7:0] = wd[7:0];
    end
    if (be[1]) begin
      r[15:8] = wd[15:8];
    end
    merge = r;
  endfunction

  // ---------------------------------------------------------------
  // byte swapping paths
  // ---------------------------------------------------------------
  // bus write data into little-endian layout
  heps_swap u_wr_swap (
    .en_i(s.big_endian),
    .data_i(avs_writedata_i),
    .data_o(wd_le)
  );

  // little-endian read data back onto the bus
  heps_swap u_rd_swap (
    .en_i(s.big_endian),
    .data_i(raw_rd),
    .data_o(rd_bus)
  );

  // second swap of stored pixels during refresh
  // stored pixels keep the bus-swapped layout, so 16 bpp swaps again
  heps_swap u_disp_swap (
    .en_i(s.disp_swap),
    .data_i(buf_mem[s.fetch_addr]),
    .data_o(disp_word)
  );

  // byte enables follow the data lanes
  assign be_le = s.big_endian ? {avs_byteenable_i[0], avs_byteenable_i[1]}
                              : avs_byteenable_i;
  assign is_buf = avs_address_i[BUF_SEL_BIT];
  assign buf_we = (s.state == ST_ACK) && avs_write_i && is_buf;

  // memory controller sleeps in power save except for a buffer write
  // awake through the wake cycle and the completing edge
  assign mc_down = s.ps_en && (s.state != ST_WAKE) && !buf_we;

  // ---------------------------------------------------------------
  // read mux, little-endian view
  // ---------------------------------------------------------------
  always_comb begin
    // reserved bits and unmapped locations read as zero
    raw_rd = '0;
    if (is_buf) begin
      // buffer reads in power save are unsupported and return zero
      if (!s.ps_en) begin
        raw_rd = buf_mem[avs_address_i[BUF_AW-1:0]];
      end
    end else if (hit(avs_address_i, DISP_CTRL_WADDR)) begin
      raw_rd[DISP_SWAP_BIT] = s.disp_swap;
    end else if (hit(avs_address_i, PWR_CTRL_WADDR)) begin
      raw_rd[PS_EN_BIT] = s.ps_en;
      raw_rd[MC_DOWN_BIT] = mc_down;
    end else if (hit(avs_address_i, GPIO_CTRL_WADDR)) begin
      raw_rd[GPIO_OUT_LSB +: GPIO_W] = s.gpio_out;
      raw_rd[GPIO_DIR_LSB +: GPIO_W] = s.gpio_dir;
    end else if (hit(avs_address_i, GPIO_STAT_WADDR)) begin
      raw_rd[GPIO_OUT_LSB +: GPIO_W] = s.gpio_s2;
    end else if (hit(avs_address_i, STRAP_STAT_WADDR)) begin
      raw_rd[STRAP_BE_BIT] = s.big_endian;
      raw_rd[STRAP_PF_BIT] = s.pin_func;
    end
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [DATA_W-1:0] upd;
    upd = '0;
    next_s = s;

    // pin synchronisers
    next_s.be_s1 = endian_select_strap_i;
    next_s.be_s2 = s.be_s1;
    next_s.pf_s1 = pin_function_strap_i;
    next_s.pf_s2 = s.pf_s1;
    next_s.gpio_s1 = gpio_i;
    next_s.gpio_s2 = s.gpio_s1;

    // host request sequencing
    case (s.state)
      ST_INIT: begin
        // straps settle through the synchronisers, then latch once
        // waitrequest stays high, so an early request simply waits
        if (s.settle_cnt == STRAP_SETTLE_CYCLES) begin
          next_s.big_endian = s.be_s2;
          next_s.pin_func = s.pf_s2;
          next_s.state = ST_IDLE;
        end else begin
          next_s.settle_cnt = s.settle_cnt + 2'h1;
        end
      end
      ST_IDLE: begin
        if (avs_read_i || avs_write_i) begin
          // read data captured now stands through the answer cycle
          next_s.rdata = rd_bus;
          // a buffer write in power save first wakes the controller
          if (avs_write_i && is_buf && s.ps_en) begin
            next_s.state = ST_WAKE;
          end else begin
            next_s.state = ST_ACK;
          end
        end
      end
      ST_WAKE: begin
        next_s.state = ST_ACK;
      end
      ST_ACK: begin
        next_s.state = ST_IDLE;
        // register writes land at the completing edge, lanes mapped
        if (avs_write_i && !is_buf) begin
          if (hit(avs_address_i, DISP_CTRL_WADDR)) begin
            upd = merge({1'b0, s.disp_swap, 14'h0000}, wd_le, be_le);
            next_s.disp_swap = upd[DISP_SWAP_BIT];
          end else if (hit(avs_address_i, PWR_CTRL_WADDR)) begin
            upd = merge({15'h0000, s.ps_en}, wd_le, be_le);
            next_s.ps_en = upd[PS_EN_BIT];
          end else if (hit(avs_address_i, GPIO_CTRL_WADDR)) begin
            upd = merge({8'h00, s.gpio_dir, s.gpio_out}, wd_le, be_le);
            next_s.gpio_out = upd[GPIO_OUT_LSB +: GPIO_W];
            next_s.gpio_dir = upd[GPIO_DIR_LSB +: GPIO_W];
          end
        end
      end
      default: begin
        next_s.state = ST_IDLE;
      end
    endcase

    // display refresh runs only outside power save
    // fetch restarts at word 0 so refresh resumes from the top
    if (s.ps_en) begin
      next_s.fetch_addr = '0;
      next_s.panel_data = '0;
      next_s.panel_de = 1'b0;
      next_s.panel_shift = 1'b0;
      next_s.pwm_cnt = '0;
    end else begin
      next_s.fetch_addr = s.fetch_addr + 8'h01;
      next_s.panel_data = disp_word;
      next_s.panel_de = 1'b1;
      next_s.panel_shift = !s.panel_shift;
      next_s.pwm_cnt = s.pwm_cnt + 4'h1;
    end

    // general-purpose pins: panel control or plain gpio
    // panel-control pins track this edge's refresh outputs
    // plain gpio keeps working in power save
    if (s.pin_func) begin
      next_s.gpio_pin = s.ps_en ? 4'h0
                        : {2'b00, next_s.panel_shift, next_s.panel_de};
      next_s.gpio_en = '1;
    end else begin
      next_s.gpio_pin = next_s.gpio_out;
      next_s.gpio_en = next_s.gpio_dir;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '0;
      s.state <= ST_INIT;
      s.ps_en <= PS_EN_RESET;
      s.disp_swap <= DISP_SWAP_RESET;
      s.gpio_out <= GPIO_OUT_RESET;
      s.gpio_dir <= GPIO_DIR_RESET;
    end else begin
      s <= next_s;
    end
  end

  // display buffer write with byte lanes
  always_ff @(posedge sys_clk_i) begin
    if (buf_we) begin
      if (be_le[0]) begin
        buf_mem[avs_address_i[BUF_AW-1:0]][7:0] <= wd_le[7:0];
      end
      if (be_le[1]) begin
        buf_mem[avs_address_i[BUF_AW-1:0]][15:8] <= wd_le[15:8];
      end
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign avs_readdata_o = s.rdata;
  // waitrequest is low only in the single answer cycle
  assign avs_waitrequest_o = (s.state != ST_ACK);
  assign panel_data_o = s.panel_data;
  assign panel_de_o = s.panel_de;
  assign panel_shift_o = s.panel_shift;
  assign pwm_source_clock_o = s.pwm_cnt[PWM_W-1];
  assign gpio_o = s.gpio_pin;
  assign gpio_oe_o = s.gpio_en;
  assign power_save_o = s.ps_en;
  assign mc_down_o = mc_down;

endmodule

// ==== logic/heps_pkg.sv ====
// constants for host endian and power save control
package heps_pkg;

  // ---------------------------------------------------------------
  // widths and sizes
  // ---------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 16;
  localparam int BUF_AW = 8;
  localparam int BUF_DEPTH = 256;
  localparam int GPIO_W = 4;
  localparam int PWM_W = 4;

  // ---------------------------------------------------------------
  // address map, word addresses on the 16-bit bus
  // ---------------------------------------------------------------
  localparam int BUF_SEL_BIT = 11;
  localparam logic [ADDR_W-1:0] DISP_CTRL_WADDR = 12'h038;
  localparam logic [ADDR_W-1:0] PWR_CTRL_WADDR = 12'h050;
  localparam logic [ADDR_W-1:0] GPIO_CTRL_WADDR = 12'h058;
  localparam logic [ADDR_W-1:0] GPIO_STAT_WADDR = 12'h059;
  localparam logic [ADDR_W-1:0] STRAP_STAT_WADDR = 12'h05a;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int DISP_SWAP_BIT = 14;
  localparam int PS_EN_BIT = 0;
  localparam int MC_DOWN_BIT = 3;
  localparam int GPIO_OUT_LSB = 0;
  localparam int GPIO_DIR_LSB = 4;
  localparam int STRAP_BE_BIT = 0;
  localparam int STRAP_PF_BIT = 1;

  // ---------------------------------------------------------------
  // reset values and counts
  // ---------------------------------------------------------------
  localparam logic PS_EN_RESET = 1'b1;
  localparam logic DISP_SWAP_RESET = 1'b0;
  localparam logic [GPIO_W-1:0] GPIO_OUT_RESET = 4'h0;
  localparam logic [GPIO_W-1:0] GPIO_DIR_RESET = 4'h0;
  localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h2;

  typedef enum logic [1:0] {
    ST_INIT,
    ST_IDLE,
    ST_WAKE,
    ST_ACK
  } heps_state_t;

endpackage

// ==== logic/heps_swap.sv ====
// conditional byte swap of one 16-bit word
`timescale 1ns/1ps
module heps_swap (
  input wire logic en_i,
  input wire logic [heps_pkg::DATA_W-1:0] data_i,
  output logic [heps_pkg::DATA_W-1:0] data_o
);
  import heps_pkg::*;

  // even byte goes to upper half when swapping
  always_comb begin
    if (en_i) begin
      data_o = {data_i[7:0], data_i[15:8]};
    end else begin
      data_o = data_i;
    end
  end

endmodule

// ==== tb/heps_core_asserts.sv ====
// concurrent checks on the core's ports
`timescale 1ns/1ps
module heps_core_asserts (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [heps_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [heps_pkg::DATA_W-1:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic [heps_pkg::DATA_W-1:0] panel_data_o,
  input wire logic panel_de_o,
  input wire logic panel_shift_o,
  input wire logic pwm_source_clock_o,
  input wire logic power_save_o,
  input wire logic mc_down_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // -------------------------------------------------------------
  // power save and bus timing
  // -------------------------------------------------------------
  ps_panel_a: assert property (power_save_o[*2] |-> !panel_de_o &&
    !panel_shift_o && panel_data_o == 16'h0000)
    else $error("panel active in power save");
  ps_pwm_a: assert property (power_save_o[*2] |-> !pwm_source_clock_o)
    else $error("pwm clock runs in power save");
  run_de_a: assert property ((!power_save_o)[*3] |-> panel_de_o)
    else $error("refresh idle in normal mode");
  run_shift_a: assert property ((!power_save_o)[*3] |=>
    panel_shift_o != $past(panel_shift_o))
    else $error("shift clock stuck in normal mode");
  mc_state_a: assert property (!power_save_o |-> !mc_down_o)
    else $error("memory controller down in normal mode");
  mc_sleep_a: assert property (power_save_o &&
    !(avs_write_i && avs_address_i[11]) |-> mc_down_o)
    else $error("memory controller awake without buffer write");
  mc_wake_a: assert property ($fell(mc_down_o) |-> !power_save_o ||
    (avs_write_i && avs_address_i[11]))
    else $error("memory controller woken without buffer write");
  wait_one_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low too long");
  wait_bound_a: assert property ((avs_read_i || avs_write_i) |->
    ##[0:8] !avs_waitrequest_o)
    else $error("bus request not answered");
  ps_bufrd_a: assert property (avs_read_i && avs_address_i[11] &&
    power_save_o && !avs_waitrequest_o |-> avs_readdata_o == 16'h0000)
    else $error("buffer read data in power save");
  cover property (avs_write_i && avs_address_i[11] && power_save_o &&
    !avs_waitrequest_o);
  cover property ($fell(power_save_o));
  cover property ($rose(power_save_o));
endmodule

// ==== tb/heps_pin_model.sv ====
// pin-side model: released pins pulled up, driven pins echoed
`timescale 1ns/1ps
module heps_pin_model (
  input wire logic [heps_pkg::GPIO_W-1:0] drv_i,
  input wire logic [heps_pkg::GPIO_W-1:0] oe_i,
  output logic [heps_pkg::GPIO_W-1:0] pin_o
);
  // undriven pins sit at the pull-up level
  assign pin_o = (drv_i & oe_i) | ~oe_i;
endmodule

// ==== tb/tb_heps_core.sv ====
// self-checking bench for the endian and power save core
`timescale 1ns/1ps
module tb_heps_core;
  import heps_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic be_s = 1'b0;
  logic pf_s = 1'b0;
  logic [ADDR_W-1:0] ad = 12'h000;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [DATA_W-1:0] wd = 16'h0000;
  logic [1:0] ben = 2'h3;
  logic [DATA_W-1:0] rq, pd, q;
  logic wq, de, sh, pwm, ps, mcd;
  logic [GPIO_W-1:0] gi, go, goe;
  int n_fail = 0;
  int samples_checked = 0;
  heps_core dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .endian_select_strap_i(be_s), .pin_function_strap_i(pf_s),
    .avs_address_i(ad), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wd), .avs_byteenable_i(ben), .avs_readdata_o(rq),
    .avs_waitrequest_o(wq), .panel_data_o(pd), .panel_de_o(de),
    .panel_shift_o(sh), .pwm_source_clock_o(pwm), .gpio_i(gi),
    .gpio_o(go), .gpio_oe_o(goe), .power_save_o(ps), .mc_down_o(mcd));
  heps_pin_model pins (.drv_i(go), .oe_i(goe), .pin_o(gi));
  // -------------------------------------------------------------
  // clock and shared tasks
  // -------------------------------------------------------------
  initial forever #5 sys_clk_i = ~sys_clk_i;
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] %0t saw %h want %h", $time, s, e);
    end
  endtask
  // one bus cycle, held until waitrequest is sampled low
  task automatic acc(input logic w, input logic [11:0] a,
    input logic [15:0] d);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    rd <= !w;
    wr <= w;
    ad <= a;
    wd <= d;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (wq !== 1'b0);
    q = rq;
    // answer within four cycles, enough for the wake cycle and for the strap settle after reset
    chk({15'h0000, n > 4}, 16'h0000);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  // straps stay put through reset and the settle edges
  task automatic rst(input logic b, input logic p);
    if (rst_n_i) begin
      @(posedge sys_clk_i);
    end
    rst_n_i <= 1'b0;
    be_s <= b;
    pf_s <= p;
    repeat (2) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
  endtask
  task automatic seek(input logic [15:0] v);
    int n;
    n = 0;
    while (pd !== v && n < 600) begin
      @(negedge sys_clk_i);
      n++;
    end
    chk(pd, v);
  endtask
  // -------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------
  task automatic t_le();
    rst(1'b0, 1'b0);
    acc(1'b0, PWR_CTRL_WADDR, 16'h0000);
    chk(q, 16'h0009);
    @(negedge sys_clk_i);
    chk({14'h0000, ps, mcd}, 16'h0003);
    acc(1'b0, STRAP_STAT_WADDR, 16'h0000);
    chk(q, 16'h0000);
    acc(1'b1, GPIO_CTRL_WADDR, 16'h00c5);
    repeat (4) @(negedge sys_clk_i);
    chk({8'h00, goe, go}, 16'h00c5);
    acc(1'b0, GPIO_STAT_WADDR, 16'h0000);
    chk(q, 16'h0007);
    acc(1'b0, 12'h100, 16'h0000);
    chk(q, 16'h0000);
    acc(1'b1, 12'h803, 16'h1234);
    acc(1'b0, 12'h803, 16'h0000);
    chk(q, 16'h0000);
    acc(1'b1, PWR_CTRL_WADDR, 16'h0000);
    acc(1'b0, PWR_CTRL_WADDR, 16'h0000);
    chk(q, 16'h0000);
    @(negedge sys_clk_i);
    chk({14'h0000, ps, mcd}, 16'h0000);
    seek(16'h1234);
    acc(1'b1, DISP_CTRL_WADDR, 16'h4000);
    seek(16'h3412);
    acc(1'b1, PWR_CTRL_WADDR, 16'h0001);
    repeat (3) @(negedge sys_clk_i);
    chk({pd[15:3], de, sh, pwm} | pd, 16'h0000);
    $display("little-endian test done");
  endtask
  task automatic t_be();
    int n;
    n = 0;
    rst(1'b1, 1'b1);
    acc(1'b0, STRAP_STAT_WADDR, 16'h0000);
    chk(q, 16'h0300);
    acc(1'b0, PWR_CTRL_WADDR, 16'h0000);
    chk(q, 16'h0900);
    chk({12'h000, go}, 16'h0000);
    acc(1'b1, 12'h805, 16'h1122);
    acc(1'b1, PWR_CTRL_WADDR, 16'h0000);
    acc(1'b0, 12'h805, 16'h0000);
    chk(q, 16'h1122);
    seek(16'h2211);
    chk({15'h0000, go[0]}, 16'h0001);
    acc(1'b1, DISP_CTRL_WADDR, 16'h0040);
    seek(16'h1122);
    repeat (32) @(negedge sys_clk_i) n += int'(pwm);
    chk(16'(n), 16'h0010);
    acc(1'b1, PWR_CTRL_WADDR, 16'h0100);
    repeat (3) @(negedge sys_clk_i);
    chk({12'h000, go}, 16'h0000);
    $display("big-endian test done");
  endtask
  task automatic results();
    $display("compares %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    t_le();
    t_be();
    results();
  end
  // watchdog well beyond the few hundred cycles of the tests
  initial begin
    #200us;
    n_fail++;
    results();
  end
endmodule
bind heps_core heps_core_asserts chk_u (.sys_clk_i(sys_clk_i),
  .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .panel_data_o(panel_data_o), .panel_de_o(panel_de_o),
  .panel_shift_o(panel_shift_o), .pwm_source_clock_o(pwm_source_clock_o),
  .power_save_o(power_save_o), .mc_down_o(mc_down_o));
